/* hw/sle_pkg.sv */
// Shared constants and carriers of the enclosure LED serial transmitter
package sle_pkg;

  // Register bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] LOC_OFS = 12'h01C;     // Buffer location word
  localparam logic [ADDR_W-1:0] CTL_OFS = 12'h020;     // Transmit and reset control
  localparam logic [ADDR_W-1:0] VEND_OFS = 12'h024;    // Vendor pattern
  localparam logic [ADDR_W-1:0] ACTSEL_OFS = 12'h028;  // Hardware activity select
  localparam logic [ADDR_W-1:0] STAT_OFS = 12'h02C;    // Link state readback
  localparam logic [ADDR_W-1:0] MSG_HDR_OFS = 12'h580; // Message header word
  localparam logic [ADDR_W-1:0] MSG_LED_OFS = 12'h584; // LED message word

  // Buffer size in words, reported in the location word
  localparam logic [15:0] MSG_BUF_WORDS = 16'h0002;

  // Control field positions
  localparam int TRANSMIT_MESSAGE_BIT_BIT = 0;
  localparam int CTL_RST_BIT = 1;

  // Header layout
  localparam int HDR_MTYPE_LSB = 24;
  localparam int HDR_MSIZE_LSB = 8;
  localparam logic [3:0] MTYPE_LED = 4'h0;
  localparam logic [7:0] LED_MSG_BYTES = 8'h04;

  // LED message layout
  localparam int LED_HBA_LSB = 0;
  localparam int LED_PM_LSB = 8;
  localparam int LED_ACT_BIT = 16;
  localparam int LED_LOC_BIT = 19;
  localparam int LED_FLT_BIT = 22;

  // Reset values
  localparam logic [2:0] LED_RST = 3'h7;
  localparam logic [3:0] VEND_RST = 4'h0;
  localparam logic [7:0] ACTSEL_RST = 8'h00;
  localparam logic [DATA_W-1:0] MSG_RST = 32'h0000_0000;

  // Port counts
  localparam int NUM_PORTS = 8;
  localparam int LEDS_PER_PORT = 3;

  // Serial clock timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_PERIOD_NS = 400;
  localparam int SCLK_DIV = SCLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SCLK_HALF = SCLK_DIV / 2;
  localparam logic [2:0] DIV_RISE = 3'(SCLK_HALF - 1);
  localparam logic [2:0] DIV_FALL = 3'(SCLK_DIV - 1);

  // Frame layout in serial clock periods
  localparam int LOAD_LOW_CYC = 5;
  localparam int VEND_BITS = 4;
  localparam int STREAM_BITS = 24;
  localparam logic [4:0] POS_LOAD = 5'(LOAD_LOW_CYC);
  localparam logic [4:0] POS_LAST = 5'(LOAD_LOW_CYC + STREAM_BITS - 1);
  localparam logic [4:0] VEND_LAST = 5'(VEND_BITS);
  localparam logic [4:0] STREAM_LAST = 5'(STREAM_BITS - 1);
  localparam logic [4:0] SEC_BASE = 5'h0C;
  localparam logic [4:0] SEC8_BITS = 5'h0C;
  localparam logic [4:0] SEC6_BITS = 5'h06;

  // Port configuration strap values
  localparam logic [1:0] CFG_4 = 2'h0;
  localparam logic [1:0] CFG_6 = 2'h1;
  localparam logic [1:0] CFG_8 = 2'h2;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sle_req_t;

  // Serial link pins, each with its output enable
  typedef struct packed {
    logic sclock;
    logic sclock_oe;
    logic sload;
    logic sload_oe;
    logic serial_led_out_primary;
    logic serial_led_out_primary_oe;
    logic serial_led_out_secondary;
    logic serial_led_out_secondary_oe;
  } sle_pins_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } sle_state_t;

endpackage

/* hw/sle_tx.sv */
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
// Contract
// - Message buffer sits at byte 580h
// - Send after transmit bit; hardware clears it
// - Only LED messages; clock, load, data
// - Runs only in AHCI or RAID mode; ahci_mode gates only message take
// - Pins floating until first transmission
// - Load low five clocks before stream
// - Load high one clock, then vendor bits
// - Primary carries 24 bits, ports 0-7
// - Eight ports: secondary 12 bits, 12 floating
// - Six ports: secondary 6 bits, 18 floating
// - Four ports: secondary always floating
// - LED bits default high; hardware activity follows
// - Unimplemented ports send all ones
// - Platform reset floats pins asynchronously
// - Soft reset finishes stream, then floats
// - Header word then four-byte LED message
// - Non-LED type changes no LED state
// - Message names port; multiplier port zero
// - Slot keeps state until its next update
module sle_tx
  import sle_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire sle_pkg::sle_req_t req,
  output logic [31:0] rdata,
  input wire logic ahci_mode,
  input wire logic hba_reset,
  input wire logic [1:0] port_cfg,
  input wire logic [7:0] ports_implemented,
  input wire logic [7:0] port_activity,
  output sle_pkg::sle_pins_t pins
);
  import sle_pkg::*;

  // Software visible state
  logic tm_r;                   // Transmit request pending
  logic stop_r;                 // Soft reset pending
  logic [3:0] vend_r;           // Vendor pattern
  logic [7:0] actsel_r;         // Activity LED driven by hardware
  logic [31:0] hdr_r;           // Message header word
  logic [31:0] msg_r;           // LED message word
  logic [31:0] rdata_r;         // Read data, one cycle after strobe

  // Per slot LED state, kept across frames
  logic [NUM_PORTS-1:0][2:0] led_r;

  // Link sequencer state
  sle_state_t st_r;             // Idle or running
  logic [2:0] div_r;            // Serial clock divider
  logic [4:0] pos_r;            // Bit position within frame
  logic sclk_r;                 // Serial clock level
  logic sload_r;                // Load level
  logic d0_r;                   // Primary data level
  logic d1_r;                   // Secondary data level
  logic d1oe_r;                 // Secondary data enable within frame
  logic drive_r;                // Link pins driven

  // Decoded strobes
  logic wr_ctl;
  logic take;                   // Message taken by hardware
  logic fall;                   // Serial clock falling edge now
  logic frame_end;              // Last falling edge of a frame
  logic hdr_is_led;
  logic msg_ok;
  logic [7:0] hba_port;

  // Next output levels for the coming bit period
  logic [4:0] npos;
  logic [4:0] k;
  logic ld_nxt;
  logic d0_nxt;
  logic d1_nxt;
  logic d1oe_nxt;

  // Effective LED stream, three bits per port in port order
  logic [STREAM_BITS-1:0] eff_v;

  // Control write decode
  assign wr_ctl = req.wr && (req.addr == CTL_OFS);

  // Header and message checks
  assign hdr_is_led = (hdr_r[HDR_MTYPE_LSB +: 4] == MTYPE_LED);
  assign hba_port = msg_r[LED_HBA_LSB +: 8];
  // Only slots without a multiplier exist here; other slots are dropped
  assign msg_ok = hdr_is_led && (hdr_r[HDR_MSIZE_LSB +: 8] == LED_MSG_BYTES)
    && (msg_r[LED_PM_LSB +: 8] == 8'h00) && (hba_port < 8'(NUM_PORTS));

  // Serial clock edges from the divider
  assign fall = (st_r == ST_RUN) && (div_r == DIV_FALL);
  assign frame_end = fall && (pos_r == POS_LAST);

  // Messages are taken only between frames so a frame never mixes old and new
  assign take = tm_r && !stop_r && ahci_mode
    && ((st_r == ST_IDLE) || frame_end);

  // Transmit request bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tm_r <= 1'b0;
    end
    // Software set wins over the hardware clear in the same cycle
    else if (wr_ctl && req.wdata[TRANSMIT_MESSAGE_BIT_BIT])
    begin
      tm_r <= 1'b1;
    end
    else if (take)
    begin
      tm_r <= 1'b0;
    end
  end

  // Soft reset request, from the control bit or an HBA reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stop_r <= 1'b0;
    end
    // New request wins over the completion clear
    else if ((wr_ctl && req.wdata[CTL_RST_BIT]) || hba_reset)
    begin
      stop_r <= 1'b1;
    end
    // Done once the link is floating again
    else if (st_r == ST_IDLE)
    begin
      stop_r <= 1'b0;
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vend_r <= VEND_RST;
      actsel_r <= ACTSEL_RST;
    end
    else if (req.wr)
    begin
      if (req.addr == VEND_OFS)
      begin
        vend_r <= req.wdata[3:0];
      end
      if (req.addr == ACTSEL_OFS)
      begin
        actsel_r <= req.wdata[7:0];
      end
    end
  end

  // Message buffer; software keeps it still while a request is pending
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hdr_r <= MSG_RST;
      msg_r <= MSG_RST;
    end
    else if (req.wr)
    begin
      if (req.addr == MSG_HDR_OFS)
      begin
        hdr_r <= req.wdata;
      end
      if (req.addr == MSG_LED_OFS)
      begin
        msg_r <= req.wdata;
      end
    end
  end

  // Slot LED state, updated only by a valid LED message
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      led_r <= {NUM_PORTS{LED_RST}};
    end
    else if (take && msg_ok)
    begin
      // Other slots hold their state untouched
      led_r[hba_port[2:0]] <= {msg_r[LED_FLT_BIT], msg_r[LED_LOC_BIT],
        msg_r[LED_ACT_BIT]};
    end
  end

  // Stream image per port: activity, locate, fault
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_eff
    // Unimplemented ports always show all ones
    assign eff_v[p*LEDS_PER_PORT +: LEDS_PER_PORT] = !ports_implemented[p] ? LED_RST
      : {led_r[p][2:1], actsel_r[p] ? port_activity[p] : led_r[p][0]};
  end

  // Register read mux; unmapped addresses read zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else if (req.rd)
    begin
      unique case (req.addr)
        // Word offset of the buffer above, its size below
        LOC_OFS: rdata_r <= {6'h00, MSG_HDR_OFS[11:2], MSG_BUF_WORDS};
        CTL_OFS: rdata_r <= {30'h0, stop_r, tm_r};
        VEND_OFS: rdata_r <= {28'h0, vend_r};
        ACTSEL_OFS: rdata_r <= {24'h0, actsel_r};
        STAT_OFS: rdata_r <= {24'h0, pos_r, sclk_r, drive_r, st_r == ST_RUN};
        MSG_HDR_OFS: rdata_r <= hdr_r;
        MSG_LED_OFS: rdata_r <= msg_r;
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
    else
    begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_r;

  // Sequencer and serial clock divider
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= ST_IDLE;
      div_r <= 3'h0;
      pos_r <= 5'h00;
      sclk_r <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        // Floating; a first valid LED message starts the link
        ST_IDLE:
        begin
          div_r <= 3'h0;
          pos_r <= 5'h00;
          sclk_r <= 1'b0;
          if (take && msg_ok)
          begin
            st_r <= ST_RUN;
          end
        end
        // Frames repeat until a soft reset lets the current one end
        ST_RUN:
        begin
          div_r <= fall ? 3'h0 : 3'(div_r + 3'h1);
          if (div_r == DIV_RISE)
          begin
            sclk_r <= 1'b1;
          end
          if (fall)
          begin
            sclk_r <= 1'b0;
            pos_r <= npos;
            if (frame_end && stop_r)
            begin
              st_r <= ST_IDLE;
            end
          end
        end
        default:
        begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Position of the next bit period
  assign npos = ((st_r == ST_IDLE) || (pos_r == POS_LAST)) ? 5'h00 : 5'(pos_r + 5'h01);

  // Levels for the bit period at npos
  always_comb
  begin
    k = 5'(npos - POS_LOAD);
    ld_nxt = 1'b0;
    d0_nxt = 1'b0;
    d1_nxt = 1'b0;
    d1oe_nxt = (port_cfg != CFG_4);
    // Load low through the preamble
    if (npos >= POS_LOAD)
    begin
      // Load high on the first stream bit, then vendor bits
      if (k == 5'h00)
      begin
        ld_nxt = 1'b1;
      end
      else if (k <= VEND_LAST)
      begin
        ld_nxt = vend_r[2'(k - 5'h01)];
      end
      if (k <= STREAM_LAST)
      begin
        d0_nxt = eff_v[k];
      end
      // Secondary repeats the upper ports, then floats
      if ((port_cfg == CFG_8) && (k < SEC8_BITS))
      begin
        d1_nxt = eff_v[5'(k + SEC_BASE)];
      end
      else if ((port_cfg == CFG_6) && (k < SEC6_BITS))
      begin
        d1_nxt = eff_v[5'(k + SEC_BASE)];
      end
      else
      begin
        d1oe_nxt = 1'b0;
      end
    end
  end

  // Data and load change only at the falling edge of the serial clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sload_r <= 1'b0;
      d0_r <= 1'b0;
      d1_r <= 1'b0;
      d1oe_r <= 1'b0;
    end
    // The first period is set up as the link starts, with clock low
    else if (fall || ((st_r == ST_IDLE) && take && msg_ok))
    begin
      sload_r <= ld_nxt;
      d0_r <= d0_nxt;
      d1_r <= d1_nxt;
      d1oe_r <= d1oe_nxt;
    end
  end

  // Pin drive; floats asynchronously on platform reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      drive_r <= 1'b0;
    end
    else if ((st_r == ST_IDLE) && take && msg_ok)
    begin
      drive_r <= 1'b1;
    end
    // Ends together with the last frame after a soft reset
    else if (frame_end && stop_r)
    begin
      drive_r <= 1'b0;
    end
  end

  // Pin bundle
  assign pins.sclock = sclk_r;
  assign pins.sclock_oe = drive_r;
  assign pins.sload = sload_r;
  assign pins.sload_oe = drive_r;
  assign pins.serial_led_out_primary = d0_r;
  assign pins.serial_led_out_primary_oe = drive_r;
  assign pins.serial_led_out_secondary = d1_r;
  // Only three signal kinds exist; the secondary line is optional
  assign pins.serial_led_out_secondary_oe = drive_r && d1oe_r;

endmodule // sle_tx

/* test/sle_tx_properties.sv */
`timescale 1ns/10ps
// Watches the serial LED link at the transmitter's ports
module sle_tx_properties
  import sle_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire sle_pkg::sle_req_t req,
  input wire logic [31:0] rdata,
  input wire logic ahci_mode,
  input wire logic hba_reset,
  input wire logic [1:0] port_cfg,
  input wire logic [7:0] ports_implemented,
  input wire logic [7:0] port_activity,
  input wire sle_pkg::sle_pins_t pins
);
  import sle_pkg::*;
  logic [4:0] pos_r; // Bit period within the frame
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Counts serial clock falls; a waking link restarts at period zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pos_r <= 5'h00;
    else if ($rose(pins.sclock_oe))
      pos_r <= 5'h00;
    else if (pins.sclock_oe && $fell(pins.sclock))
      pos_r <= (pos_r == POS_LAST) ? 5'h00 : pos_r + 5'h01;
  end
  AST_WAKE_QUIET: assert property ($fell(rst) |-> !pins.sclock_oe && !pins.sload_oe
    && !pins.serial_led_out_primary_oe && !pins.serial_led_out_secondary_oe)
    else $error("Link driven right after reset");
  AST_WAKE_LOW: assert property ($rose(pins.sclock_oe) |-> pins.sload_oe
    && pins.serial_led_out_primary_oe && !pins.sclock)
    else $error("Link woke in a bad state");
  AST_SCLK_HIGH: assert property ($rose(pins.sclock) |-> pins.sclock[*4] ##1 !pins.sclock)
    else $error("Serial clock high phase wrong");
  AST_PREAMBLE: assert property ($rose(pins.sclock) && pos_r < POS_LOAD
    |-> !pins.sload && !pins.serial_led_out_primary)
    else $error("Load not low in preamble");
  AST_LOAD_HIGH: assert property ($rose(pins.sclock) && pos_r == POS_LOAD |-> pins.sload)
    else $error("Load pulse missing");
  AST_EDGE: assert property (pins.sload_oe && $past(pins.sload_oe)
    && ($changed(pins.sload) || $changed(pins.serial_led_out_primary)) |-> $fell(pins.sclock))
    else $error("Output moved off the falling edge");
  AST_SEC8: assert property ($rose(pins.sclock) && port_cfg == CFG_8
    |-> pins.serial_led_out_secondary_oe == (pos_r <= 5'h10))
    else $error("Secondary drive wrong for eight ports");
  AST_SEC6: assert property ($rose(pins.sclock) && port_cfg == CFG_6
    |-> pins.serial_led_out_secondary_oe == (pos_r <= 5'h0A))
    else $error("Secondary drive wrong for six ports");
  AST_SEC4: assert property (port_cfg == CFG_4 |-> !pins.serial_led_out_secondary_oe)
    else $error("Secondary driven with four ports");
  // Main scenarios: wake, full frame, float again
  cover property ($rose(pins.sclock_oe));
  cover property ($rose(pins.sclock) && pos_r == POS_LAST);
  cover property ($fell(pins.sclock_oe));
endmodule // sle_tx_properties

/* test/sle_encl_model.sv */
`timescale 1ns/10ps
// Enclosure controller: shifts in frames on rising serial clock
module sle_encl_model
  import sle_pkg::*;
(
  input wire logic clk,
  input wire sle_pkg::sle_pins_t pins,
  output logic [23:0] prim,
  output logic [3:0] vend,
  output logic [23:0] sec,
  output logic [23:0] sec_oe,
  output logic [7:0] frames
);
  import sle_pkg::*;
  logic sclk_q; // Serial clock one cycle ago
  int low_run; // Low load samples in a row
  int idx; // Stream bit index, 24 when idle
  logic [23:0] p_r, s_r, so_r;
  logic [3:0] v_r;
  initial
  begin
    sclk_q = 1'b0;
    low_run = 0;
    idx = 24;
    frames = 8'h00;
  end
  // Samples mid bit, so a change at the fall is never caught
  always @(posedge clk)
  begin
    sclk_q <= pins.sclock;
    // A floating link abandons any half-seen frame
    if (!pins.sclock_oe)
    begin
      idx = 24;
      low_run = 0;
    end
    if (pins.sclock_oe && pins.sclock && !sclk_q)
    begin
      // Start only after a long enough low load run
      if (pins.sload && low_run >= LOAD_LOW_CYC)
        idx = 0;
      else if (idx < 24)
        idx = idx + 1;
      low_run = pins.sload ? 0 : low_run + 1;
      if (idx < 24)
      begin
        p_r[idx] = pins.serial_led_out_primary;
        s_r[idx] = pins.serial_led_out_secondary_oe & pins.serial_led_out_secondary;
        so_r[idx] = pins.serial_led_out_secondary_oe;
        if (idx >= 1 && idx <= 4)
          v_r[idx-1] = pins.sload;
        if (idx == 23)
        begin
          prim <= p_r;
          sec <= s_r;
          sec_oe <= so_r;
          vend <= v_r;
          frames <= frames + 8'h01;
        end
      end
    end
  end
endmodule // sle_encl_model

/* test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import sle_pkg::*;
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sle_row_t;
  logic clk, rst, ahci_mode, hba_reset;
  logic [1:0] port_cfg;
  logic [7:0] ports_implemented, port_activity, m_frames, f0, fr;
  logic [31:0] rdata;
  logic [3:0] m_vend, acc;
  logic [23:0] m_prim, m_sec, m_sec_oe;
  sle_req_t req;
  sle_pins_t pins;
  int err_count, compares, n;
  // Register rows: writes carry data, reads carry the expected word
  sle_row_t rows [11] = '{'{1'b0, LOC_OFS, 32'h0160_0002}, '{1'b0, CTL_OFS, 32'h0},
    '{1'b0, VEND_OFS, 32'h0}, '{1'b0, ACTSEL_OFS, 32'h0}, '{1'b0, 12'h100, 32'h0},
    '{1'b1, VEND_OFS, 32'h5}, '{1'b0, VEND_OFS, 32'h5}, '{1'b1, MSG_HDR_OFS, 32'h400},
    '{1'b0, MSG_HDR_OFS, 32'h400}, '{1'b1, MSG_LED_OFS, 32'h0040_0002},
    '{1'b0, MSG_LED_OFS, 32'h0040_0002}};
  sle_tx i_dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .ahci_mode(ahci_mode),
    .hba_reset(hba_reset), .port_cfg(port_cfg), .ports_implemented(ports_implemented),
    .port_activity(port_activity), .pins(pins));
  sle_encl_model i_mdl (.clk(clk), .pins(pins), .prim(m_prim), .vend(m_vend), .sec(m_sec),
    .sec_oe(m_sec_oe), .frames(m_frames));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    // Taken at the next edge, before the design clears it
    @(posedge clk);
    check(rdata, e);
  endtask
  function automatic logic [3:0] oes();
    return {pins.sclock_oe, pins.sload_oe, pins.serial_led_out_primary_oe,
      pins.serial_led_out_secondary_oe};
  endfunction
  // Second frame is checked, the first may predate the take
  task automatic chk_frame(input logic [23:0] p, input logic [23:0] oe, input logic [3:0] v);
    f0 = m_frames;
    n = 0;
    while (m_frames - f0 != 8'h02 && n < 1200)
    begin
      @(posedge clk);
      n++;
    end
    check({24'h0, m_frames - f0}, 32'h2);
    check({8'h00, m_prim}, {8'h00, p});
    check({8'h00, m_sec_oe}, {8'h00, oe});
    check({8'h00, m_sec}, {20'h00000, p[23:12]} & {8'h00, oe});
    check({28'h0, m_vend}, {28'h0, v});
  endtask
  // Waits for the link to float, then the frame count
  task automatic soft_end();
    n = 0;
    while (pins.sclock_oe !== 1'b0 && n < 600)
    begin
      @(posedge clk);
      n++;
    end
    check({24'h0, m_frames - fr}, 32'h1);
    acc = 4'h0;
    repeat (300)
    begin
      @(posedge clk);
      acc |= oes();
    end
    check({28'h0, acc}, 32'h0);
  endtask
  task give_verdict;
    $display("Errors %0d, compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #(30000 * 50);
    err_count++;
    $display("CHECK FAILED at %0t: watchdog got %h expected %h", $time, 1'b1, 1'b0);
    give_verdict();
  end
  initial
  begin
    rst = 1'b1;
    req = '0;
    ahci_mode = 1'b1;
    hba_reset = 1'b0;
    port_cfg = CFG_4;
    ports_implemented = 8'hFF;
    port_activity = 8'hFF;
    err_count = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
      if (rows[i].wr)
        bus_wr(rows[i].addr, rows[i].data);
      else
        bus_rd(rows[i].addr, rows[i].data);
    check({28'h0, oes()}, 32'h0);
    port_cfg <= CFG_8;
    bus_wr(CTL_OFS, 32'h1);
    chk_frame(24'hFFFF3F, 24'h000FFF, 4'h5);
    bus_rd(CTL_OFS, 32'h0);
    ports_implemented <= 8'hFB;
    chk_frame(24'hFFFFFF, 24'h000FFF, 4'h5);
    ports_implemented <= 8'hFF;
    bus_wr(MSG_HDR_OFS, 32'h0100_0400);
    bus_wr(MSG_LED_OFS, 32'h0040_0000);
    bus_wr(CTL_OFS, 32'h1);
    chk_frame(24'hFFFF3F, 24'h000FFF, 4'h5);
    bus_rd(CTL_OFS, 32'h0);
    bus_wr(ACTSEL_OFS, 32'h1);
    port_activity <= 8'hFE;
    chk_frame(24'hFFFF3E, 24'h000FFF, 4'h5);
    repeat (40) @(posedge clk);
    fr = m_frames;
    bus_wr(CTL_OFS, 32'h2);
    soft_end();
    bus_rd(CTL_OFS, 32'h0);
    port_cfg <= CFG_6;
    ahci_mode <= 1'b0;
    bus_wr(MSG_HDR_OFS, 32'h400);
    bus_wr(MSG_LED_OFS, 32'h0008_0003);
    bus_wr(CTL_OFS, 32'h1);
    repeat (20) @(posedge clk);
    bus_rd(CTL_OFS, 32'h1);
    check({28'h0, oes()}, 32'h0);
    ahci_mode <= 1'b1;
    chk_frame(24'hFFF53E, 24'h00003F, 4'h5);
    repeat (40) @(posedge clk);
    fr = m_frames;
    hba_reset <= 1'b1;
    @(posedge clk);
    hba_reset <= 1'b0;
    soft_end();
    bus_wr(CTL_OFS, 32'h1);
    repeat (100) @(posedge clk);
    #13 rst = 1'b1;
    #1 check({28'h0, oes()}, 32'h0);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    port_cfg <= CFG_4;
    repeat (300) @(posedge clk);
    check({28'h0, oes()}, 32'h0);
    bus_rd(VEND_OFS, 32'h0);
    // Four-port frame after platform reset, vendor bits still at default
    bus_wr(MSG_HDR_OFS, 32'h400);
    bus_wr(MSG_LED_OFS, 32'h0008_0001);
    bus_wr(CTL_OFS, 32'h1);
    chk_frame(24'hFFFFD7, 24'h000000, 4'h0);
    give_verdict();
  end
endmodule // tb_top
bind sle_tx sle_tx_properties i_chk (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
  .ahci_mode(ahci_mode), .hba_reset(hba_reset), .port_cfg(port_cfg),
  .ports_implemented(ports_implemented), .port_activity(port_activity), .pins(pins));
